// ---- include/brac_pkg.sv ----
// Constants, register map and field layout of the bus region access checker.
// How it works
// - Sixteen region descriptors, four words each.
// - Start and end bound each region, 32-byte grain.
// - Checker disabled after reset, everything passes.
// - Core master: separate supervisor/user read, write, execute.
// - DMA and network masters: read and write only; master code 3 is never granted.
// - Hardware clears a descriptor's valid bit when its start, end or access word is written.
// - Alternate view rewrites access word only.
// - Any granting overlapping region allows access.
// - Both slave ports checked concurrently.
// - Permitted references complete at the slave.
// - No hit or all denied flags error.
// - Error response; slave never sees cycle.
// - Per port 64-bit record of last fault.
package brac_pkg;
    localparam int          NUM_REGIONS    = 16;
    localparam int          NUM_PORTS      = 2;
    localparam int          GRAN_BITS      = 5;
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_MASK      = 12'h008;
    localparam logic [11:0] ADDR_ERR_BASE  = 12'h010;
    localparam logic [11:0] ADDR_DESC_BASE = 12'h400;
    localparam logic [11:0] ADDR_ALT_BASE  = 12'h800;
    localparam logic [1:0]  WORD_START     = 2'h0;
    localparam logic [1:0]  WORD_END       = 2'h1;
    localparam logic [1:0]  WORD_ACCESS    = 2'h2;
    localparam logic [1:0]  WORD_VALID     = 2'h3;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          PERM_R         = 0;
    localparam int          PERM_W         = 1;
    localparam int          PERM_X         = 2;
    localparam int          ACC_USR_LO     = 0;
    localparam int          ACC_SUP_LO     = 3;
    localparam int          ACC_DMA_LO     = 6;
    localparam int          ACC_NET_LO     = 8;
    localparam int          ERR_WR_BIT     = 0;
    localparam int          ERR_EX_BIT     = 1;
    localparam int          ERR_SUP_BIT    = 2;
    localparam int          ERR_MST_LO     = 4;
    localparam int          ERR_HIT_LO     = 16;
    localparam logic [1:0]  MST_CORE       = 2'h0;
    localparam logic [1:0]  MST_DMA        = 2'h1;
    localparam logic [1:0]  MST_NET        = 2'h2;
    localparam logic [31:0] RST_CTRL       = 32'h0000_0000;
    localparam logic [31:0] RST_MASK       = 32'h0000_0000;
    localparam logic [31:0] RST_START      = 32'h0000_0000;
    localparam logic [31:0] RST_END        = 32'hffff_ffff;
    localparam logic [31:0] RST_ACCESS     = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : brac_pkg

// ---- include/brac_req_if.sv ----
`timescale 1ns/10ps
// Request attributes of one monitored port and the verdict of its checker.
interface brac_req_if;
    logic [31:0]                      addr;
    logic                             write;
    logic                             exec;
    logic                             superMode;
    logic [1:0]                       master;
    logic                             allow;
    logic [brac_pkg::NUM_REGIONS-1:0] hitMask;
    modport top (output addr, write, exec, superMode, master, input allow, hitMask);
    modport chk (input addr, write, exec, superMode, master, output allow, hitMask);
endinterface : brac_req_if

// ---- core/brac_port_checker.sv ----
`timescale 1ns/10ps
// Combinational region match and permission check for one slave port.
module brac_port_checker (
    input  wire logic [brac_pkg::NUM_REGIONS-1:0][31:0] regionStart,
    input  wire logic [brac_pkg::NUM_REGIONS-1:0][31:0] regionEnd,
    input  wire logic [brac_pkg::NUM_REGIONS-1:0][31:0] regionAccess,
    input  wire logic [brac_pkg::NUM_REGIONS-1:0]       regionValid,
    input  wire logic                                   enabled,
    brac_req_if.chk                                     req
);
    logic [brac_pkg::NUM_REGIONS-1:0] grant;
    logic [brac_pkg::NUM_REGIONS-1:0] inRange;

    for (genvar i = 0; i < brac_pkg::NUM_REGIONS; i++) begin : g_region
        logic [2:0] core;
        assign inRange[i] = regionValid[i] && req.addr >= regionStart[i]
                            && req.addr <= regionEnd[i];
        assign core = req.superMode ? regionAccess[i][brac_pkg::ACC_SUP_LO +: 3]
                                    : regionAccess[i][brac_pkg::ACC_USR_LO +: 3];
        always_comb begin
            grant[i] = 1'b0;
            if (inRange[i]) begin
                unique case (req.master)
                    brac_pkg::MST_CORE: begin
                        grant[i] = req.exec  ? core[brac_pkg::PERM_X] :
                                   req.write ? core[brac_pkg::PERM_W] : core[brac_pkg::PERM_R];
                    end
                    brac_pkg::MST_DMA: begin
                        grant[i] = regionAccess[i][brac_pkg::ACC_DMA_LO + 32'(req.write)];
                    end
                    brac_pkg::MST_NET: begin
                        grant[i] = regionAccess[i][brac_pkg::ACC_NET_LO + 32'(req.write)];
                    end
                    default: begin
                        grant[i] = 1'b0;
                    end
                endcase
            end
        end
    end

    assign req.hitMask = inRange;
    // A disabled checker passes everything; otherwise one grant suffices.
    assign req.allow   = !enabled || (|grant);
endmodule : brac_port_checker

// ---- core/bus_region_access_checker.sv ----
`timescale 1ns/10ps
// Region access checker: register slave, two monitored ports, fault records.
module bus_region_access_checker (
    input  wire logic                                 clk_sys,
    input  wire logic                                 rst,
    input  wire logic [11:0]                          awaddr,
    input  wire logic                                 awvalid,
    output logic                                      awready,
    input  wire logic [31:0]                          wdata,
    input  wire logic [3:0]                           wstrb,
    input  wire logic                                 wvalid,
    output logic                                      wready,
    output logic [1:0]                                bresp,
    output logic                                      bvalid,
    input  wire logic                                 bready,
    input  wire logic [11:0]                          araddr,
    input  wire logic                                 arvalid,
    output logic                                      arready,
    output logic [31:0]                               rdata,
    output logic [1:0]                                rresp,
    output logic                                      rvalid,
    input  wire logic                                 rready,
    input  wire logic [brac_pkg::NUM_PORTS-1:0]       mReq,
    input  wire logic [brac_pkg::NUM_PORTS-1:0][31:0] mAddr,
    input  wire logic [brac_pkg::NUM_PORTS-1:0]       mWrite,
    input  wire logic [brac_pkg::NUM_PORTS-1:0]       mExec,
    input  wire logic [brac_pkg::NUM_PORTS-1:0]       mSuper,
    input  wire logic [brac_pkg::NUM_PORTS-1:0][1:0]  mMaster,
    output logic [brac_pkg::NUM_PORTS-1:0]            mReady,
    output logic [brac_pkg::NUM_PORTS-1:0]            mErr,
    output logic [brac_pkg::NUM_PORTS-1:0]            sReq,
    input  wire logic [brac_pkg::NUM_PORTS-1:0]       sReady,
    output logic                                      irq
);
    localparam int NR = brac_pkg::NUM_REGIONS;
    localparam int NP = brac_pkg::NUM_PORTS;

    logic [31:0]          ctrl;
    logic [31:0]          status;
    logic [31:0]          mask;
    logic [NR-1:0][31:0]  regionStart;
    logic [NR-1:0][31:0]  regionEnd;
    logic [NR-1:0][31:0]  regionAccess;
    logic [NR-1:0]        regionValid;
    logic [NP-1:0][31:0]  errAddr;
    logic [NP-1:0][31:0]  errDetail;
    logic [31:0]          next_ctrl;
    logic [31:0]          next_status;
    logic [31:0]          next_mask;
    logic [NR-1:0][31:0]  next_regionStart;
    logic [NR-1:0][31:0]  next_regionEnd;
    logic [NR-1:0][31:0]  next_regionAccess;
    logic [NR-1:0]        next_regionValid;
    logic [NP-1:0][31:0]  next_errAddr;
    logic [NP-1:0][31:0]  next_errDetail;

    logic                 awHeld;
    logic [11:0]          awAddrQ;
    logic                 wHeld;
    logic [31:0]          wDataQ;
    logic [3:0]           wStrbQ;
    logic                 next_awHeld;
    logic [11:0]          next_awAddrQ;
    logic                 next_wHeld;
    logic [31:0]          next_wDataQ;
    logic [3:0]           next_wStrbQ;
    logic                 next_bvalid;
    logic [1:0]           next_bresp;
    logic                 next_rvalid;
    logic [31:0]          next_rdata;
    logic [1:0]           next_rresp;
    logic                 doWrite;
    logic [NP-1:0]        allow;
    logic [NP-1:0][NR-1:0] hitMask;

    // Monitored ports: each has its own checker working in parallel.
    for (genvar p = 0; p < NP; p++) begin : g_port
        brac_req_if reqIf ();
        assign reqIf.addr   = mAddr[p];
        assign reqIf.write  = mWrite[p];
        assign reqIf.exec   = mExec[p];
        assign reqIf.superMode = mSuper[p];
        assign reqIf.master = mMaster[p];
        assign allow[p]     = reqIf.allow;
        assign hitMask[p]   = reqIf.hitMask;
        brac_port_checker u_chk (
            .regionStart  (regionStart),
            .regionEnd    (regionEnd),
            .regionAccess (regionAccess),
            .regionValid  (regionValid),
            .enabled      (ctrl[brac_pkg::CTRL_EN_BIT]),
            .req          (reqIf.chk)
        );
        // A denied reference is answered at once and never reaches the slave.
        assign sReq[p]   = mReq[p] && allow[p];
        assign mErr[p]   = mReq[p] && !allow[p];
        assign mReady[p] = allow[p] ? sReady[p] : mReq[p];
    end

    assign irq     = |(status & mask);
    assign awready = !awHeld && !bvalid;
    assign wready  = !wHeld && !bvalid;
    assign arready = !rvalid;
    assign doWrite = awHeld && wHeld && !bvalid;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic isDesc(input logic [11:0] a);
        return a[11:8] == brac_pkg::ADDR_DESC_BASE[11:8];
    endfunction : isDesc

    function automatic logic isAlt(input logic [11:0] a);
        return a[11:6] == brac_pkg::ADDR_ALT_BASE[11:6];
    endfunction : isAlt

    function automatic logic isErr(input logic [11:0] a);
        return a[11:4] == brac_pkg::ADDR_ERR_BASE[11:4];
    endfunction : isErr

    // Bus handshake state.
    always_comb begin
        next_awHeld  = awHeld;
        next_awAddrQ = awAddrQ;
        next_wHeld   = wHeld;
        next_wDataQ  = wDataQ;
        next_wStrbQ  = wStrbQ;
        next_bvalid  = bvalid && !bready;
        next_bresp   = bresp;
        next_rvalid  = rvalid && !rready;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (awvalid && awready) begin
            next_awHeld  = 1'b1;
            next_awAddrQ = awaddr;
        end
        if (wvalid && wready) begin
            next_wHeld  = 1'b1;
            next_wDataQ = wdata;
            next_wStrbQ = wstrb;
        end
        if (doWrite) begin
            next_awHeld = 1'b0;
            next_wHeld  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = brac_pkg::RESP_SLVERR;
            if (awAddrQ == brac_pkg::ADDR_CTRL || awAddrQ == brac_pkg::ADDR_STATUS
                || awAddrQ == brac_pkg::ADDR_MASK || isDesc(awAddrQ)
                || isAlt(awAddrQ) || isErr(awAddrQ)) begin
                next_bresp = brac_pkg::RESP_OKAY;
            end
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp  = brac_pkg::RESP_OKAY;
            next_rdata  = 32'h0000_0000;
            if (araddr == brac_pkg::ADDR_CTRL) begin
                next_rdata = ctrl;
            end else if (araddr == brac_pkg::ADDR_STATUS) begin
                next_rdata = status;
            end else if (araddr == brac_pkg::ADDR_MASK) begin
                next_rdata = mask;
            end else if (isErr(araddr)) begin
                next_rdata = araddr[2] ? errDetail[araddr[3]] : errAddr[araddr[3]];
            end else if (isAlt(araddr)) begin
                next_rdata = regionAccess[araddr[5:2]];
            end else if (isDesc(araddr)) begin
                unique case (araddr[3:2])
                    brac_pkg::WORD_START:  next_rdata = regionStart[araddr[7:4]];
                    brac_pkg::WORD_END:    next_rdata = regionEnd[araddr[7:4]];
                    brac_pkg::WORD_ACCESS: next_rdata = regionAccess[araddr[7:4]];
                    brac_pkg::WORD_VALID:  next_rdata = {31'h0, regionValid[araddr[7:4]]};
                endcase
            end else begin
                next_rresp = brac_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awHeld  <= 1'b0;
            awAddrQ <= 12'h000;
            wHeld   <= 1'b0;
            wDataQ  <= 32'h0000_0000;
            wStrbQ  <= 4'h0;
            bvalid  <= 1'b0;
            bresp   <= brac_pkg::RESP_OKAY;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= brac_pkg::RESP_OKAY;
        end else begin
            awHeld  <= next_awHeld;
            awAddrQ <= next_awAddrQ;
            wHeld   <= next_wHeld;
            wDataQ  <= next_wDataQ;
            wStrbQ  <= next_wStrbQ;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
        end
    end

    // Register file, descriptors and fault records.
    always_comb begin
        logic [3:0] di;
        di = awAddrQ[7:4];
        next_ctrl         = ctrl;
        next_mask         = mask;
        next_status       = status;
        next_regionStart  = regionStart;
        next_regionEnd    = regionEnd;
        next_regionAccess = regionAccess;
        next_regionValid  = regionValid;
        next_errAddr      = errAddr;
        next_errDetail    = errDetail;
        if (doWrite) begin
            if (awAddrQ == brac_pkg::ADDR_CTRL) begin
                next_ctrl = merge(ctrl, wDataQ, wStrbQ) & 32'h0000_0001;
            end else if (awAddrQ == brac_pkg::ADDR_MASK) begin
                next_mask = merge(mask, wDataQ, wStrbQ) & 32'h0000_0003;
            end else if (awAddrQ == brac_pkg::ADDR_STATUS) begin
                next_status = status & ~merge(32'h0, wDataQ, wStrbQ);
            end else if (isAlt(awAddrQ)) begin
                next_regionAccess[awAddrQ[5:2]] =
                    merge(regionAccess[awAddrQ[5:2]], wDataQ, wStrbQ);
            end else if (isDesc(awAddrQ)) begin
                // Editing the start, end or access word drops it out of use until revalidated.
                next_regionValid[di] = 1'b0;
                unique case (awAddrQ[3:2])
                    brac_pkg::WORD_START: begin
                        next_regionStart[di] = merge(regionStart[di], wDataQ, wStrbQ)
                                               & ~32'(2**brac_pkg::GRAN_BITS - 1);
                    end
                    brac_pkg::WORD_END: begin
                        next_regionEnd[di] = merge(regionEnd[di], wDataQ, wStrbQ)
                                             | 32'(2**brac_pkg::GRAN_BITS - 1);
                    end
                    brac_pkg::WORD_ACCESS: begin
                        next_regionAccess[di] = merge(regionAccess[di], wDataQ, wStrbQ);
                    end
                    brac_pkg::WORD_VALID: begin
                        next_regionValid[di] = wStrbQ[0] ? wDataQ[0] : regionValid[di];
                    end
                endcase
            end
        end
        // Fault capture comes after the clear so a new fault is never lost.
        for (int p = 0; p < NP; p++) begin
            if (mErr[p]) begin
                next_status[p]   = 1'b1;
                next_errAddr[p]  = mAddr[p];
                next_errDetail[p] = 32'h0;
                next_errDetail[p][brac_pkg::ERR_WR_BIT]  = mWrite[p];
                next_errDetail[p][brac_pkg::ERR_EX_BIT]  = mExec[p];
                next_errDetail[p][brac_pkg::ERR_SUP_BIT] = mSuper[p];
                next_errDetail[p][brac_pkg::ERR_MST_LO +: 2] = mMaster[p];
                next_errDetail[p][brac_pkg::ERR_HIT_LO +: NR] = hitMask[p];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl         <= brac_pkg::RST_CTRL;
            mask         <= brac_pkg::RST_MASK;
            status       <= 32'h0000_0000;
            regionStart  <= {NR{brac_pkg::RST_START}};
            regionEnd    <= {NR{brac_pkg::RST_END}};
            regionAccess <= {NR{brac_pkg::RST_ACCESS}};
            regionValid  <= '0;
            errAddr      <= '0;
            errDetail    <= '0;
        end else begin
            ctrl         <= next_ctrl;
            mask         <= next_mask;
            status       <= next_status;
            regionStart  <= next_regionStart;
            regionEnd    <= next_regionEnd;
            regionAccess <= next_regionAccess;
            regionValid  <= next_regionValid;
            errAddr      <= next_errAddr;
            errDetail    <= next_errDetail;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_OPEN_WHEN_OFF: assert property (
        !ctrl[brac_pkg::CTRL_EN_BIT] && mReq[0] |-> sReq[0] && !mErr[0])
        else $error("Disabled checker blocked a reference.");
    AST_ALLOW_PASSES: assert property (
        mReq[1] && allow[1] |-> sReq[1] && mReady[1] == sReady[1] && !mErr[1])
        else $error("Allowed reference did not reach the slave.");
    AST_NO_HIT_FAULT: assert property (
        ctrl[brac_pkg::CTRL_EN_BIT] && mReq[0] && hitMask[0] == '0 |-> mErr[0])
        else $error("Unmapped reference not flagged.");
    AST_DENY_BLOCKS: assert property (
        mErr[0] |-> !sReq[0] && mReady[0])
        else $error("Denied reference reached the slave.");
    AST_ERR_ADDR: assert property (
        mErr[0] |=> errAddr[0] == $past(mAddr[0]) && status[0])
        else $error("Fault address not captured on port 0.");
    AST_ERR_DETAIL: assert property (
        mErr[1] |=> errDetail[1][brac_pkg::ERR_WR_BIT] == $past(mWrite[1])
                    && errAddr[1] == $past(mAddr[1]))
        else $error("Fault record not captured on port 1.");
    AST_DESC_INVALID: assert property (
        doWrite && isDesc(awAddrQ) && awAddrQ[3:2] != brac_pkg::WORD_VALID
        |=> !regionValid[$past(awAddrQ[7:4])])
        else $error("Descriptor stayed valid after an edit.");
    AST_ALT_BOUNDS: assert property (
        doWrite && isAlt(awAddrQ) |=> $stable(regionStart) && $stable(regionEnd)
                                      && $stable(regionValid))
        else $error("Alternate view disturbed region bounds.");
    AST_IRQ_FOLLOWS: assert property (
        mErr[1] && mask[1] && !doWrite |=> irq)
        else $error("Fault did not raise the interrupt.");

    COV_DENY: cover property (mErr[0] ##1 mErr[1]);
    COV_PASS: cover property (ctrl[0] && sReq[1] && sReady[1]);
    COV_ALT:  cover property (doWrite && isAlt(awAddrQ));
    COV_IRQ:  cover property (irq ##[1:20] !irq);
endmodule : bus_region_access_checker

// ---- test/brac_slave_model.sv ----
`timescale 1ns/10ps
// Slave side: the memory answers at once, the peripheral bridge adds one wait state.
module brac_slave_model (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [1:0] sReq,
    output logic      [1:0] sReady
);
    logic waited;
    logic next_waited;
    always_comb begin
        next_waited = sReq[1] & ~waited;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            waited <= 1'b0;
        end else begin
            waited <= next_waited;
        end
    end
    // The bridge stalls so that a forwarded reference really waits on its slave.
    assign sReady = {sReq[1] & waited, sReq[0]};
endmodule : brac_slave_model

// ---- test/tb.sv ----
`timescale 1ns/10ps
// Self-checking bench for the bus region access checker.
module tb;
    logic            clk_sys, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic            arvalid, arready, rvalid, rready, irq, sup;
    logic [11:0]     awaddr, araddr;
    logic [31:0]     wdata, rdata, seed;
    logic [3:0]      wstrb;
    logic [1:0]      bresp, rresp, mReq, mWrite, mExec, mSuper, mReady, mErr, sReq, sReady, mst;
    logic [1:0][31:0] mAddr;
    logic [1:0][1:0] mMaster;
    logic [33:0]     rdQ[$];
    logic            refQ[$];
    logic [1:0]      bQ[$];
    int              errors, checked, cyc, kind;
    bus_region_access_checker u_dut (.clk_sys, .rst, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready, .mReq, .mAddr, .mWrite, .mExec, .mSuper,
        .mMaster, .mReady, .mErr, .sReq, .sReady, .irq);
    brac_slave_model u_slave (.clk_sys, .rst, .sReq, .sReady);
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic [11:0] da(input int i, input int w);
        return 12'(brac_pkg::ADDR_DESC_BASE + i * 16 + w * 4);
    endfunction : da
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
        logic ga, gw;
        ga = 1'b0;
        gw = 1'b0;
        @(posedge clk_sys);
        bQ.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ga && gw)) begin
            @(posedge clk_sys);
            ga = ga | awready;
            gw = gw | wready;
            if (ga) awvalid <= 1'b0;
            if (gw) wvalid <= 1'b0;
        end
        do @(posedge clk_sys); while (!bvalid);
        bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e = 2'h0);
        @(posedge clk_sys);
        rdQ.push_back({e, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (!rvalid);
        rready <= 1'b0;
    endtask : axr
    // The argument wxs packs write, fetch and supervisor in that order.
    task automatic mref(input int p, input logic [31:0] a, input logic [2:0] wxs,
                        input logic [1:0] m, input logic e);
        @(posedge clk_sys);
        refQ.push_back(e);
        mReq[p] <= 1'b1;
        mAddr[p] <= a;
        {mWrite[p], mExec[p], mSuper[p]} <= wxs;
        mMaster[p] <= m;
        #1;
        chk(sReq[p], !e);
        do @(posedge clk_sys); while (!mReady[p]);
        mReq[p] <= 1'b0;
    endtask : mref
    always @(posedge clk_sys) begin
        if (rvalid && rready) chk({rresp, rdata}, rdQ.pop_front());
        if (bvalid && bready) chk(bresp, bQ.pop_front());
        for (int p = 0; p < 2; p++) begin
            if (mReq[p] && mReady[p]) chk(mErr[p], refQ.pop_front());
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, mReq} = 8'hff;
        {awvalid, wvalid, bready, arvalid, rready, mReq, mWrite, mExec, mSuper} = 13'h0;
        {awaddr, araddr, wdata, mAddr, mMaster} = 124'h0;
        wstrb = 4'hf;
        seed = 32'h0000_d694;
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        mref(0, 32'h0000_5000, 3'h4, brac_pkg::MST_DMA, 1'b0);
        axr(brac_pkg::ADDR_CTRL, 32'h0);
        axr(da(15, 1), brac_pkg::RST_END);
        $display("test reset done");
        axw(da(0, 0), 32'h0000_1000);
        axw(da(0, 1), 32'h0000_1000);
        axw(da(0, 3), 32'h1);
        axw(brac_pkg::ADDR_CTRL, 32'h1);
        axr(da(0, 1), 32'h0000_101f);
        for (int k = 0; k < 10; k++) begin
            kind = (k < 6) ? k % 3 : k % 2;
            mst = (k < 6) ? brac_pkg::MST_CORE : (k < 8) ? brac_pkg::MST_DMA : brac_pkg::MST_NET;
            sup = (k >= 3 && k < 6);
            axw(brac_pkg::ADDR_ALT_BASE, 32'h1 << k);
            mref(k % 2, 32'h0000_1010, {kind == 1, kind == 2, sup}, mst, 1'b0);
            mref(0, 32'h0000_1010, {kind == 0, 1'b0, sup}, mst, 1'b1);
        end
        axr(da(0, 3), 32'h1);
        axr(da(0, 0), 32'h0000_1000);
        $display("test permissions done");
        axw(brac_pkg::ADDR_ALT_BASE, 32'h3ff);
        repeat (4) begin
            seed = xs(seed);
            mref(seed[0], {27'h80, seed[5:1]}, {seed[6], 1'b0, seed[7]}, 2'h0, 1'b0);
        end
        mref(0, 32'h0000_0fff, 3'h0, brac_pkg::MST_CORE, 1'b1);
        mref(1, 32'h0000_1020, 3'h0, brac_pkg::MST_CORE, 1'b1);
        axw(brac_pkg::ADDR_ALT_BASE, 32'h0);
        mref(1, 32'h0000_1014, 3'h4, brac_pkg::MST_DMA, 1'b1);
        axr(brac_pkg::ADDR_ERR_BASE + 12'h8, 32'h0000_1014);
        axr(brac_pkg::ADDR_ERR_BASE + 12'hc, 32'h0001_0011);
        axr(brac_pkg::ADDR_STATUS, 32'h3);
        chk(irq, 1'b0);
        axw(brac_pkg::ADDR_MASK, 32'h2);
        chk(irq, 1'b1);
        axw(brac_pkg::ADDR_STATUS, 32'h3);
        chk(irq, 1'b0);
        axr(brac_pkg::ADDR_STATUS, 32'h0);
        $display("test faults done");
        axw(da(0, 2), 32'h40);
        axr(da(0, 3), 32'h0);
        axw(da(0, 3), 32'h1);
        axw(da(1, 0), 32'h0000_1000);
        axw(da(1, 1), 32'h0000_1000);
        axw(da(1, 2), 32'h80);
        axw(da(1, 3), 32'h1);
        mref(0, 32'h0000_1008, 3'h4, brac_pkg::MST_DMA, 1'b0);
        mref(1, 32'h0000_1008, 3'h0, brac_pkg::MST_DMA, 1'b0);
        mref(0, 32'h0000_1008, 3'h0, brac_pkg::MST_NET, 1'b1);
        mref(1, 32'h0000_1008, 3'h0, 2'h3, 1'b1);
        axr(12'h0f0, 32'h0, brac_pkg::RESP_SLVERR);
        axw(12'h0f0, 32'h5, brac_pkg::RESP_SLVERR);
        $display("test overlap done");
        final_report();
    end
endmodule : tb
